// ### rtl/quad_dac_serial_input.sv
// Serial write front end of a quad 8-bit converter with AXI4-Lite status access.
// The link pins are asynchronous to mclk_i and are oversampled through
// two-flop synchronisers; serial clock edges are found in the mclk_i domain.
`timescale 1ns/1ps

module quad_dac_serial_input #(
	parameter int CNT_BITS = 8
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Serial link
	input  wire logic        sclk_i,
	input  wire logic        sync_n_i,
	input  wire logic        din_i,
	// Converter side
	output logic [7:0]       chan_a_out_o,
	output logic [7:0]       chan_b_out_o,
	output logic [7:0]       chan_c_out_o,
	output logic [7:0]       chan_d_out_o,
	output logic [1:0]       pd_term_o,
	output logic             powered_down_o,
	output logic             update_o,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// Pin synchronisers: stage 1 feeds stage 2 only
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic       sclk_d;
	logic       sync_d;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pin_s1 <= 3'h3;
			pin_s2 <= 3'h3;
			sclk_d <= 1'b1;
			sync_d <= 1'b1;
		end else begin
			pin_s1 <= {din_i, sync_n_i, sclk_i};
			pin_s2 <= pin_s1;
			sclk_d <= pin_s2[0];
			sync_d <= pin_s2[1];
		end
	end

	logic sclk_s;
	logic sync_s;
	logic din_s;
	logic sclk_fall;
	logic sync_fall;
	logic sync_rise;

	assign sclk_s    = pin_s2[0];
	assign sync_s    = pin_s2[1];
	assign din_s     = pin_s2[2];
	assign sclk_fall = sclk_d & ~sclk_s;
	assign sync_fall = sync_d & ~sync_s;
	assign sync_rise = ~sync_d & sync_s;

	// Link state
	logic [14:0]         shift;
	logic [4:0]          bit_cnt;
	logic                done;
	logic [7:0]          code [quad_dac_pkg::NUM_CHAN];
	logic [1:0]          pd_term;
	logic                upd;
	logic [CNT_BITS-1:0] frames;
	logic [CNT_BITS-1:0] aborts;
	logic                link_en;

	logic [14:0]         next_shift;
	logic [4:0]          next_bit_cnt;
	logic                next_done;
	logic [7:0]          next_code [quad_dac_pkg::NUM_CHAN];
	logic [1:0]          next_pd_term;
	logic                next_upd;
	logic [CNT_BITS-1:0] next_frames;
	logic [CNT_BITS-1:0] next_aborts;

	// Completed word fields, MSB first on the wire
	logic [15:0] word;
	logic [1:0]  w_chan;
	logic [1:0]  w_mode;
	logic [7:0]  w_data;

	assign word   = {shift, din_s};
	assign w_chan = word[quad_dac_pkg::CHAN_MSB:quad_dac_pkg::CHAN_LSB];
	assign w_mode = word[quad_dac_pkg::MODE_MSB:quad_dac_pkg::MODE_LSB];
	assign w_data = word[quad_dac_pkg::DATA_MSB:quad_dac_pkg::DATA_LSB];

	always_comb begin
		next_shift   = shift;
		next_bit_cnt = bit_cnt;
		next_done    = done;
		next_code    = code;
		next_pd_term = pd_term;
		next_upd     = 1'b0;
		next_frames  = frames;
		next_aborts  = aborts;
		if (sync_fall) begin
			next_bit_cnt = quad_dac_pkg::BIT_CNT_RESET;
			next_done    = 1'b0;
		end else if (sync_rise) begin
			if (!done) begin
				next_aborts = aborts + 1'b1;
			end
			next_bit_cnt = quad_dac_pkg::BIT_CNT_RESET;
			next_done    = 1'b1;
		end else if (!sync_s && sclk_fall && !done && link_en) begin
			next_shift   = word[14:0];
			next_bit_cnt = bit_cnt + 1'b1;
			if (bit_cnt == 5'(quad_dac_pkg::WORD_BITS - 1)) begin
				next_done   = 1'b1;
				next_frames = frames + 1'b1;
				case (w_mode)
					quad_dac_pkg::MODE_SINGLE: begin
						next_code[w_chan] = w_data;
						next_pd_term      = quad_dac_pkg::TERM_ACTIVE;
						next_upd          = 1'b1;
					end
					quad_dac_pkg::MODE_ALL: begin
						for (int i = 0; i < quad_dac_pkg::NUM_CHAN; i++) begin
							next_code[i] = w_data;
						end
						next_pd_term = quad_dac_pkg::TERM_ACTIVE;
						next_upd     = 1'b1;
					end
					quad_dac_pkg::MODE_PDOWN: begin
						if (w_chan != quad_dac_pkg::TERM_ACTIVE) begin
							next_pd_term = w_chan;
						end
					end
					default: begin
						next_pd_term = pd_term;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			shift   <= 15'h0000;
			bit_cnt <= quad_dac_pkg::BIT_CNT_RESET;
			done    <= 1'b1;
			for (int i = 0; i < quad_dac_pkg::NUM_CHAN; i++) begin
				code[i] <= quad_dac_pkg::CODE_RESET;
			end
			pd_term <= quad_dac_pkg::TERM_ACTIVE;
			upd     <= 1'b0;
			frames  <= '0;
			aborts  <= '0;
		end else begin
			shift   <= next_shift;
			bit_cnt <= next_bit_cnt;
			done    <= next_done;
			code    <= next_code;
			pd_term <= next_pd_term;
			upd     <= next_upd;
			frames  <= next_frames;
			aborts  <= next_aborts;
		end
	end

	assign chan_a_out_o   = code[0];
	assign chan_b_out_o   = code[1];
	assign chan_c_out_o   = code[2];
	assign chan_d_out_o   = code[3];
	assign pd_term_o      = pd_term;
	assign powered_down_o = (pd_term != quad_dac_pkg::TERM_ACTIVE);
	assign update_o       = upd;

	// AXI4-Lite write path: address and data taken in either order
	logic        aw_got;
	logic        w_got;
	logic [3:0]  aw_addr;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        next_aw_got;
	logic        next_w_got;
	logic [3:0]  next_aw_addr;
	logic [31:0] next_w_data_q;
	logic [3:0]  next_w_strb_q;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_link_en;

	assign s_axi_awready = ~aw_got & ~bvalid;
	assign s_axi_wready  = ~w_got & ~bvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;

	always_comb begin
		next_aw_got   = aw_got;
		next_w_got    = w_got;
		next_aw_addr  = aw_addr;
		next_w_data_q = w_data_q;
		next_w_strb_q = w_strb_q;
		next_bvalid   = bvalid;
		next_bresp    = bresp;
		next_link_en  = link_en;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got  = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got    = 1'b1;
			next_w_data_q = s_axi_wdata;
			next_w_strb_q = s_axi_wstrb;
		end
		if (aw_got && w_got) begin
			next_aw_got = 1'b0;
			next_w_got  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = quad_dac_pkg::RESP_OKAY;
			case (aw_addr)
				quad_dac_pkg::CTRL_OFFS: begin
					if (w_strb_q[0]) begin
						next_link_en = w_data_q[quad_dac_pkg::LINK_EN_BIT];
					end
				end
				quad_dac_pkg::STATUS_OFFS,
				quad_dac_pkg::CODES_OFFS: begin
					next_bresp = quad_dac_pkg::RESP_OKAY;
				end
				default: begin
					next_bresp = quad_dac_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			aw_got   <= 1'b0;
			w_got    <= 1'b0;
			aw_addr  <= 4'h0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= quad_dac_pkg::RESP_OKAY;
			link_en  <= quad_dac_pkg::CTRL_RESET;
		end else begin
			aw_got   <= next_aw_got;
			w_got    <= next_w_got;
			aw_addr  <= next_aw_addr;
			w_data_q <= next_w_data_q;
			w_strb_q <= next_w_strb_q;
			bvalid   <= next_bvalid;
			bresp    <= next_bresp;
			link_en  <= next_link_en;
		end
	end

	// AXI4-Lite read path: data one cycle after the address is taken
	logic        rvalid;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	assign s_axi_arready = ~rvalid;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;

	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = quad_dac_pkg::RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				quad_dac_pkg::CTRL_OFFS: begin
					next_rdata[quad_dac_pkg::LINK_EN_BIT] = link_en;
				end
				quad_dac_pkg::STATUS_OFFS: begin
					next_rdata[1:0]   = pd_term;
					next_rdata[2]     = ~sync_s;
					next_rdata[15:8]  = 8'(frames);
					next_rdata[23:16] = 8'(aborts);
				end
				quad_dac_pkg::CODES_OFFS: begin
					next_rdata = {code[3], code[2], code[1], code[0]};
				end
				default: begin
					next_rresp = quad_dac_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= quad_dac_pkg::RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

endmodule

// ### rtl/quad_dac_pkg.sv
// Constants for the quad converter serial input front end.
// Assumes one 250 MHz system clock and an AXI4-Lite register master.
// Functional notes
// - After frame sync falls, each serial clock falling edge shifts data into 16 bits.
// - Host opens a frame with sync low; bits are taken only while sync is low.
// - The 16th falling edge completes the word and updates the addressed outputs.
// - Sync rising before the 16th edge aborts; partial word dropped, outputs unchanged.
// - Word splits into channel select, update mode, 8-bit code and four unused low bits.
// - Two mode bits choose single-channel update, all-four update or power-down; code 2 is reserved.
// - Reset holds all output codes at zero until the first complete valid frame.
// - Power-down is commanded by the word, with three output termination choices.
package quad_dac_pkg;

	localparam int WORD_BITS = 16;
	localparam int CODE_BITS = 8;
	localparam int NUM_CHAN  = 4;

	// Command word layout
	localparam int CHAN_MSB = 15;
	localparam int CHAN_LSB = 14;
	localparam int MODE_MSB = 13;
	localparam int MODE_LSB = 12;
	localparam int DATA_MSB = 11;
	localparam int DATA_LSB = 4;

	// Update modes
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_ALL    = 2'h1;
	localparam logic [1:0] MODE_RSVD   = 2'h2;
	localparam logic [1:0] MODE_PDOWN  = 2'h3;

	// Power-down terminations, carried in the channel field
	localparam logic [1:0] TERM_ACTIVE = 2'h0;
	localparam logic [1:0] TERM_1K     = 2'h1;
	localparam logic [1:0] TERM_100K   = 2'h2;
	localparam logic [1:0] TERM_HIZ    = 2'h3;

	// Register map (byte addresses)
	localparam logic [3:0] CTRL_OFFS   = 4'h0;
	localparam logic [3:0] STATUS_OFFS = 4'h4;
	localparam logic [3:0] CODES_OFFS  = 4'h8;
	localparam logic       CTRL_RESET  = 1'b1;
	localparam int         LINK_EN_BIT = 0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [7:0] CODE_RESET  = 8'h00;
	localparam logic [4:0] BIT_CNT_RESET = 5'h00;

	// Serial clock limit and the sampling rate it is checked against
	localparam int SCLK_MAX_MHZ = 40;
	localparam int MCLK_MHZ     = 250;
	localparam int MCLK_PER_SCLK_HALF = MCLK_MHZ / (2 * SCLK_MAX_MHZ);

endpackage

// ### dv/host_link.sv
// Host side of the serial write link: frame sync, serial clock and data.
// The bench calls send; the link clock stands high outside frames.
`timescale 1ns/1ps
module host_link;
	logic sclk   = 1'b1;
	logic sync_n = 1'b1;
	logic din    = 1'b0;
	// Fewer than 16 bits ends the frame early
	task automatic send(input logic [15:0] w, input int n);
		#1 sync_n = 1'b0;
		#62.5;
		for (int i = 15; i > 15 - n; i--) begin
			din = w[i];
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		#62.5 sync_n = 1'b1;
		din = ~din;
		#250;
	endtask
endmodule

// ### dv/quad_dac_chk.sv
// Assertions on the converter front end, bound to its top module.
// Sees only top-level ports; everything is in the mclk_i domain.
`timescale 1ns/1ps
module quad_dac_chk (
	input wire logic       mclk_i,
	input wire logic       rst_n_i,
	input wire logic       sync_n_i,
	input wire logic [7:0] chan_a_out_o,
	input wire logic [7:0] chan_b_out_o,
	input wire logic [7:0] chan_c_out_o,
	input wire logic [7:0] chan_d_out_o,
	input wire logic [1:0] pd_term_o,
	input wire logic       powered_down_o,
	input wire logic       update_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [31:0] codes;
	assign codes = {chan_d_out_o, chan_c_out_o, chan_b_out_o, chan_a_out_o};
	sequence link_idle;
		sync_n_i [*8];
	endsequence
	sequence one_pulse;
		update_o ##1 !update_o;
	endsequence
	reset_zero_a: assert property (
		$rose(rst_n_i) |-> codes == 32'h0000_0000 && !update_o)
		else $error("outputs not cleared by reset");
	code_cause_a: assert property (
		!$stable(codes) |-> ##[0:2] update_o)
		else $error("code changed without update");
	update_pulse_a: assert property (
		update_o |-> one_pulse)
		else $error("update pulse too long");
	update_frame_a: assert property (
		update_o |-> !sync_n_i)
		else $error("update outside a frame");
	idle_hold_a: assert property (
		link_idle |-> $stable(codes) && $stable(pd_term_o))
		else $error("outputs moved while link idle");
	pd_flag_a: assert property (
		powered_down_o == (pd_term_o != 2'h0))
		else $error("power-down flag disagrees with termination");
	pd_exit_a: assert property (
		update_o |-> pd_term_o == quad_dac_pkg::TERM_ACTIVE)
		else $error("update left device powered down");
	pd_frame_a: assert property (
		!$stable(pd_term_o) |-> !sync_n_i)
		else $error("termination changed outside a frame");
endmodule

bind quad_dac_serial_input quad_dac_chk u_quad_dac_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n_i),
	.chan_a_out_o(chan_a_out_o), .chan_b_out_o(chan_b_out_o),
	.chan_c_out_o(chan_c_out_o), .chan_d_out_o(chan_d_out_o), .pd_term_o(pd_term_o),
	.powered_down_o(powered_down_o), .update_o(update_o));

// ### dv/quad_dac_serial_input_bench.sv
// Self-checking bench: serial frames from the host model, AXI4-Lite register reads.
// Drivers queue expected values; monitors compare them when results appear.
`timescale 1ns/1ps
module quad_dac_serial_input_bench;
	logic        mclk_i  = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  awaddr  = 4'h0;
	logic [3:0]  araddr  = 4'h0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, brd = 1'b0, rrd = 1'b0;
	logic        awr, wr, bv, arr, rv, pdn, upd;
	logic [7:0]  ca, cb, cc, cd;
	logic [7:0]  code [4];
	logic [1:0]  pd, bresp, rresp, term;
	logic [31:0] rdata;
	logic        en;
	logic [3:0]  wstrb   = 4'hf;
	logic [2:0]  pd_seen = 3'h0;
	logic [31:0] q_up[$], q_mk[$];
	logic [33:0] q_rd[$];
	logic [1:0]  q_wr[$];
	logic [2:0]  q_pd[$];
	int          err_total = 0, cmp_count = 0, cyc = 0, nf = 0, na = 0;

	always #2 mclk_i = ~mclk_i;
	host_link u_host_link ();
	quad_dac_serial_input u_quad_dac_serial_input (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(u_host_link.sclk),
		.sync_n_i(u_host_link.sync_n), .din_i(u_host_link.din),
		.chan_a_out_o(ca), .chan_b_out_o(cb), .chan_c_out_o(cc), .chan_d_out_o(cd),
		.pd_term_o(pd), .powered_down_o(pdn), .update_o(upd),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd));

	task automatic note(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic cmp_codes(input logic [31:0] g, input logic [31:0] e);
		note(g === e, "channel codes");
	endtask
	task automatic cmp_read(input logic [33:0] g, input logic [33:0] e);
		note(g === e, "register read");
	endtask
	task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
		note(g === e, "write response");
	endtask
	task automatic cmp_term(input logic [2:0] g, input logic [2:0] e);
		note(g === e, "power-down termination");
	endtask
	task automatic test_done();
		$display("Compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge mclk_i) begin
		if (rst_n_i && upd === 1'b1) begin
			if (q_up.size() == 0) note(1'b0, "unexpected update");
			else cmp_codes({cd, cc, cb, ca}, q_up.pop_front());
		end
		if (rst_n_i && {pdn, pd} !== pd_seen) begin
			pd_seen = {pdn, pd};
			if (q_pd.size() == 0) note(1'b0, "unexpected termination change");
			else cmp_term(pd_seen, q_pd.pop_front());
		end
		if (bv === 1'b1 && brd) cmp_resp(bresp, q_wr.pop_front());
		if (rv === 1'b1 && rrd) cmp_read({rresp, rdata} & {2'h3, q_mk.pop_front()}, q_rd.pop_front());
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end

	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] e);
		logic ta, tw, tb;
		q_wr.push_back(e);
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do begin
			@(negedge mclk_i);
			ta = awv & awr;
			tw = wv & wr;
			tb = bv;
			@(posedge mclk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (tb !== 1'b1);
		brd <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a, input logic [33:0] e, input logic [31:0] m);
		logic ta, tb;
		q_rd.push_back(e);
		q_mk.push_back(m);
		@(posedge mclk_i);
		araddr <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		do begin
			@(negedge mclk_i);
			ta = arv & arr;
			tb = rv;
			@(posedge mclk_i);
			if (ta) arv <= 1'b0;
		end while (tb !== 1'b1);
		rrd <= 1'b0;
	endtask
	task automatic chk();
		axr(quad_dac_pkg::CODES_OFFS, {quad_dac_pkg::RESP_OKAY, code[3], code[2], code[1],
			code[0]}, 32'hffff_ffff);
		axr(quad_dac_pkg::STATUS_OFFS, {quad_dac_pkg::RESP_OKAY, 8'h00, 8'(na), 8'(nf), 6'h00,
			term}, 32'hffff_ffff);
	endtask
	task automatic frame(input logic [1:0] ch, input logic [1:0] md, input logic [7:0] d,
		input int n);
		logic [1:0] was;
		was = term;
		if (!(n == 16 && en)) na++;
		if (n == 16 && en) begin
			nf++;
			if (md == quad_dac_pkg::MODE_SINGLE) code[ch] = d;
			if (md == quad_dac_pkg::MODE_ALL) code = '{4{d}};
			if (md[1] == 1'b0) term = 2'h0;
			if (md[1] == 1'b0) q_up.push_back({code[3], code[2], code[1], code[0]});
			if (md == quad_dac_pkg::MODE_PDOWN && ch != 2'h0) term = ch;
		end
		if (term != was) q_pd.push_back({term != 2'h0, term});
		u_host_link.send({ch, md, d, 4'h0}, n);
		chk();
	endtask

	initial begin
		void'($urandom(63));
		code = '{4{8'h00}};
		term = 2'h0;
		en = 1'b1;
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk();
		for (int i = 0; i < 4; i++) frame(2'(i), 2'h0, 8'($urandom), 16);
		frame(2'h2, quad_dac_pkg::MODE_ALL, 8'($urandom), 16);
		frame(2'h1, quad_dac_pkg::MODE_SINGLE, 8'h5a, 15);
		frame(2'h3, quad_dac_pkg::MODE_ALL, 8'hc3, 1);
		for (int t = 1; t < 4; t++) frame(2'(t), quad_dac_pkg::MODE_PDOWN, 8'h00, 16);
		frame(2'h0, quad_dac_pkg::MODE_PDOWN, 8'h00, 16);
		frame(2'h3, quad_dac_pkg::MODE_SINGLE, 8'hff, 16);
		frame(2'h2, quad_dac_pkg::MODE_RSVD, 8'h81, 16);
		axw(quad_dac_pkg::CTRL_OFFS, 32'h0000_0000, 4'hf, quad_dac_pkg::RESP_OKAY);
		en = 1'b0;
		frame(2'h1, quad_dac_pkg::MODE_ALL, 8'h3c, 16);
		axw(quad_dac_pkg::CTRL_OFFS, 32'h0000_0001, 4'hf, quad_dac_pkg::RESP_OKAY);
		en = 1'b1;
		axw(quad_dac_pkg::CTRL_OFFS, 32'h0000_0000, 4'he, quad_dac_pkg::RESP_OKAY);
		axw(quad_dac_pkg::STATUS_OFFS, 32'hffff_ffff, 4'hf, quad_dac_pkg::RESP_OKAY);
		axw(4'hc, 32'h0000_0000, 4'hf, quad_dac_pkg::RESP_SLVERR);
		axr(quad_dac_pkg::CTRL_OFFS, {quad_dac_pkg::RESP_OKAY, 32'h0000_0001}, 32'h0000_0001);
		axr(4'hc, {quad_dac_pkg::RESP_SLVERR, 32'h0000_0000}, 32'hffff_ffff);
		frame(2'h1, quad_dac_pkg::MODE_SINGLE, 8'($urandom), 16);
		note(q_up.size() == 0 && q_pd.size() == 0 && q_wr.size() == 0, "result missing");
		test_done();
	end
endmodule
